// *** hdl/cmd_bridge_pkg.sv ***
package cmd_bridge_pkg;
  localparam int CHAR_W = 8;
  localparam int WORD_W = 32;
  localparam int BITS_W = 6;
  localparam int NIB_W = 4;
  localparam int NIB_LOG2 = 2;
  localparam int BYTE_BITS = 8;
  localparam int DEC_RADIX = 10;
  localparam int PHASE_W = 3;

  // pause timing, least time rounded up to whole cycles
  localparam int CLK_PERIOD_NS = 4;
  localparam int PAUSE_TIME_NS = 2_000_000;
  localparam int PAUSE_CYCLES = (PAUSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef logic [CHAR_W-1:0] char_t;

  // command characters
  localparam char_t CH_WR_U = 8'h57;
  localparam char_t CH_WR_L = 8'h77;
  localparam char_t CH_RD_U = 8'h52;
  localparam char_t CH_RD_L = 8'h72;
  localparam char_t CH_N_U = 8'h4e;
  localparam char_t CH_N_L = 8'h6e;
  localparam char_t CH_I_U = 8'h49;
  localparam char_t CH_I_L = 8'h69;
  localparam char_t CH_M_U = 8'h4d;
  localparam char_t CH_M_L = 8'h6d;
  localparam char_t CH_L_U = 8'h4c;
  localparam char_t CH_L_L = 8'h6c;
  localparam char_t CH_HEX_U = 8'h58;
  localparam char_t CH_HEX_L = 8'h78;
  localparam char_t CH_TERM_U = 8'h54;
  localparam char_t CH_TERM_L = 8'h74;
  localparam char_t CH_SEL = 8'h24;
  localparam char_t CH_PAUSE = 8'h2e;
  localparam char_t CH_COMMA = 8'h2c;
  localparam char_t CH_SPACE = 8'h20;
  localparam char_t CH_TAB = 8'h09;
  localparam char_t CH_CR = 8'h0d;
  localparam char_t CH_ZERO = 8'h30;
  localparam char_t CH_ONE = 8'h31;
  localparam char_t CH_NINE = 8'h39;
  localparam char_t CH_A_LO = 8'h61;
  localparam char_t CH_F_LO = 8'h66;

  typedef enum logic [1:0] {LEN_8, LEN_16, LEN_24, LEN_32} len_e;
  typedef enum logic [1:0] {M_NONE, M_WRITE, M_READ} cmd_mode_e;
  typedef enum logic [1:0] {S_IDLE, S_XFER, S_EMIT, S_PAUSE} state_e;

  // reset values
  localparam logic RST_HEX_MODE = 1'b1;
  localparam logic RST_VERBOSE = 1'b0;
  localparam logic RST_SEL_N = 1'b1;
  localparam char_t RST_DELIM = CH_SPACE;
  localparam len_e RST_LEN = LEN_8;

  // link-side bit phases: sclk high for the upper half
  localparam logic [PHASE_W-1:0] PH_RISE = 3'h3;
  localparam logic [PHASE_W-1:0] PH_LAST = 3'h7;

  function automatic logic [BITS_W-1:0] lenBits(input len_e c);
    return BITS_W'((int'(c) + 1) * BYTE_BITS);
  endfunction
endpackage

// *** hdl/spi_shift_engine.sv ***
`timescale 1ns/1ps
module spi_shift_engine (
  input wire logic linkClk,
  input wire logic srst,
  spi_xfer_if.engine xfer,
  output logic sclk,
  output logic mosi,
  input wire logic miso
);
  import cmd_bridge_pkg::*;

  logic rstMeta_reg;
  logic rstLink_reg;
  logic reqMeta_reg;
  logic reqSync_reg;
  logic reqSeen_reg;
  logic misoMeta_reg;
  logic misoSync_reg;
  logic active_reg;
  logic [PHASE_W-1:0] phase_reg;
  logic [BITS_W-1:0] bitsLeft_reg;
  logic [WORD_W-1:0] txShift_reg;
  logic [WORD_W-1:0] rxShift_reg;
  logic [WORD_W-1:0] rxWord_reg;
  logic ackToggle_reg;
  logic sclk_reg;
  logic start;
  logic bitEnd;
  logic wordEnd;

  //////////////////////////////////////////////////////////////////////
  // decode
  assign start = !active_reg && (reqSync_reg != reqSeen_reg);
  assign bitEnd = active_reg && (phase_reg == PH_LAST);
  assign wordEnd = bitEnd && (bitsLeft_reg == BITS_W'(1));
  assign sclk = sclk_reg;
  assign mosi = txShift_reg[WORD_W-1]; // msb first, zeros once drained
  assign xfer.ackToggle = ackToggle_reg;
  assign xfer.rxWord = rxWord_reg;

  //////////////////////////////////////////////////////////////////////
  // reset and miso synchronisers
  always_ff @(posedge linkClk)
  begin
    rstMeta_reg <= srst;
    rstLink_reg <= rstMeta_reg;
    misoMeta_reg <= miso;
    misoSync_reg <= misoMeta_reg;
  end

  // request toggle crossing
  always_ff @(posedge linkClk)
  begin
    if (rstLink_reg)
    begin
      reqMeta_reg <= 1'b0;
      reqSync_reg <= 1'b0;
      reqSeen_reg <= 1'b0;
    end
    else
    begin
      reqMeta_reg <= xfer.reqToggle;
      reqSync_reg <= reqMeta_reg;
      if (start)
        reqSeen_reg <= reqSync_reg;
    end
  end

  // shifter; one sclk pulse per bit, no more
  always_ff @(posedge linkClk)
  begin
    if (rstLink_reg)
    begin
      active_reg <= 1'b0;
      phase_reg <= '0;
      bitsLeft_reg <= '0;
      txShift_reg <= '0;
      rxShift_reg <= '0;
    end
    else if (start)
    begin
      active_reg <= 1'b1;
      phase_reg <= '0;
      bitsLeft_reg <= xfer.nBits;
      txShift_reg <= xfer.txWord;
      rxShift_reg <= '0;
    end
    else if (active_reg)
    begin
      phase_reg <= PHASE_W'(phase_reg + 1'b1);
      if (bitEnd)
      begin
        txShift_reg <= {txShift_reg[WORD_W-2:0], 1'b0};
        rxShift_reg <= {rxShift_reg[WORD_W-2:0], misoSync_reg};
        bitsLeft_reg <= BITS_W'(bitsLeft_reg - 1'b1);
        if (wordEnd)
          active_reg <= 1'b0;
      end
    end
  end

  // result word and acknowledge; sampling late hides the sync delay
  always_ff @(posedge linkClk)
  begin
    if (rstLink_reg)
    begin
      rxWord_reg <= '0;
      ackToggle_reg <= 1'b0;
      sclk_reg <= 1'b0;
    end
    else
    begin
      sclk_reg <= active_reg && (phase_reg >= PH_RISE) && (phase_reg != PH_LAST);
      if (wordEnd)
      begin
        rxWord_reg <= {rxShift_reg[WORD_W-2:0], misoSync_reg};
        ackToggle_reg <= !ackToggle_reg;
      end
    end
  end
endmodule // spi_shift_engine

// *** hdl/spi_xfer_if.sv ***
`timescale 1ns/1ps
interface spi_xfer_if;
  import cmd_bridge_pkg::*;
  logic reqToggle;
  logic [WORD_W-1:0] txWord;
  logic [BITS_W-1:0] nBits;
  logic ackToggle;
  logic [WORD_W-1:0] rxWord;
  // words stay still while their toggle crosses
  modport cmd (output reqToggle, output txWord, output nBits, input ackToggle, input rxWord);
  modport engine (input reqToggle, input txWord, input nBits, output ackToggle, output rxWord);
endinterface // spi_xfer_if

// *** hdl/uart_to_spi_command_bridge.sv ***
`timescale 1ns/1ps
module uart_to_spi_command_bridge #(
  parameter int PauseCycles = cmd_bridge_pkg::PAUSE_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic linkClk,
  input wire logic [cmd_bridge_pkg::CHAR_W-1:0] rxChar,
  input wire logic rxValid,
  output logic rxReady,
  output logic [cmd_bridge_pkg::CHAR_W-1:0] txChar,
  output logic txValid,
  input wire logic txReady,
  output logic selectLineN,
  output logic hexMode,
  output logic verboseMode,
  output logic sclk,
  output logic mosi,
  input wire logic miso
);
  import cmd_bridge_pkg::*;

  state_e state_reg;
  state_e state_next;
  cmd_mode_e mode_reg;
  len_e len_reg;
  char_t delim_reg;
  char_t txChar_reg;
  logic hexMode_reg;
  logic verbose_reg;
  logic selN_reg;
  logic dollarPend_reg;
  logic haveNum_reg;
  logic outAny_reg;
  logic [WORD_W-1:0] accum_reg;
  logic [WORD_W-1:0] pauseCnt_reg;
  logic reqToggle_reg;
  logic [WORD_W-1:0] txWord_reg;
  logic [BITS_W-1:0] nBits_reg;
  logic xferIsRead_reg;
  logic ackMeta_reg;
  logic ackSync_reg;
  logic [WORD_W-1:0] shift_reg;
  logic [BITS_W-1:0] nibLeft_reg;
  logic pendDelim_reg;
  logic pendCr_reg;
  logic stale_reg;

  spi_xfer_if xfer ();

  //////////////////////////////////////////////////////////////////////
  // character decoding
  function automatic logic isDec(input char_t c);
    return (c >= CH_ZERO) && (c <= CH_NINE);
  endfunction

  function automatic logic isLenChar(input char_t c);
    return (c == CH_N_U) || (c == CH_N_L) || (c == CH_I_U) || (c == CH_I_L) ||
           (c == CH_M_U) || (c == CH_M_L) || (c == CH_L_U) || (c == CH_L_L);
  endfunction

  function automatic len_e lenOf(input char_t c);
    if ((c == CH_I_U) || (c == CH_I_L))
      return LEN_16;
    if ((c == CH_M_U) || (c == CH_M_L))
      return LEN_24;
    if ((c == CH_L_U) || (c == CH_L_L))
      return LEN_32;
    return LEN_8;
  endfunction

  function automatic char_t hexAscii(input logic [NIB_W-1:0] n);
    if (n < NIB_W'(DEC_RADIX))
      return char_t'(CH_ZERO + n);
    return char_t'(CH_A_LO + n - NIB_W'(DEC_RADIX));
  endfunction

  logic hexLetter;
  logic numIn;
  logic lenIn;
  len_e chLen;
  logic [NIB_W-1:0] nibVal;
  logic isDelimChar;
  logic take;
  logic flushWrite;
  logic launchWrite;
  logic launchRead;
  logic xferGo;
  logic pauseGo;
  logic crEmit;
  logic xferDone;
  logic txAccept;
  logic lastOut;
  logic [WORD_W-1:0] xferData;
  logic [BITS_W-1:0] xferBits;
  logic [BITS_W-1:0] shAmt;
  logic [BITS_W-1:0] rxShAmt;
  char_t outChar;

  // lower-case a-f only count as digits in hex mode
  assign hexLetter = hexMode_reg && (rxChar >= CH_A_LO) && (rxChar <= CH_F_LO);
  assign numIn = !dollarPend_reg && (isDec(rxChar) || hexLetter);
  assign lenIn = !dollarPend_reg && isLenChar(rxChar);
  assign chLen = lenOf(rxChar);
  assign nibVal = isDec(rxChar) ? NIB_W'(rxChar - CH_ZERO)
                                : NIB_W'(rxChar - CH_A_LO + DEC_RADIX);
  assign isDelimChar = (rxChar == CH_COMMA) || (rxChar == CH_SPACE) || (rxChar == CH_TAB);

  //////////////////////////////////////////////////////////////////////
  // flow control and launch conditions
  // a pending write value goes out before the char that ends it is eaten
  assign flushWrite = (mode_reg == M_WRITE) && haveNum_reg && !numIn;
  assign rxReady = (state_reg == S_IDLE) && !flushWrite;
  assign take = rxValid && rxReady;
  assign launchWrite = (state_reg == S_IDLE) && rxValid && flushWrite;
  assign launchRead = take && (mode_reg == M_READ) && lenIn;
  assign xferGo = launchWrite || launchRead;
  assign pauseGo = take && (rxChar == CH_PAUSE) && !dollarPend_reg;
  assign crEmit = take && (rxChar == CH_CR) && (mode_reg == M_READ) && outAny_reg;
  assign xferDone = (state_reg == S_XFER) && (ackSync_reg == reqToggle_reg);
  assign txAccept = txValid && txReady;
  assign lastOut = !pendDelim_reg && (nibLeft_reg <= BITS_W'(1));

  // transfer word: plain reads send zeros, address reads 8 bits
  assign xferData = (launchWrite || haveNum_reg) ? accum_reg : '0;
  assign xferBits = launchWrite ? lenBits(len_reg) :
                    haveNum_reg ? lenBits(LEN_8) : lenBits(chLen);
  assign shAmt = BITS_W'(WORD_W) - xferBits;
  assign rxShAmt = BITS_W'(WORD_W) - nBits_reg;

  // outgoing text: separator, nibbles msb first, then a closing cr
  assign outChar = pendDelim_reg ? delim_reg :
                   (nibLeft_reg != '0) ? hexAscii(shift_reg[WORD_W-1 -: NIB_W]) : CH_CR;
  assign txValid = (state_reg == S_EMIT) && !stale_reg;
  assign txChar = txChar_reg;
  assign selectLineN = selN_reg;
  assign hexMode = hexMode_reg;
  assign verboseMode = verbose_reg;
  assign xfer.reqToggle = reqToggle_reg;
  assign xfer.txWord = txWord_reg;
  assign xfer.nBits = nBits_reg;

  //////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE:
        if (pauseGo)
          state_next = S_PAUSE;
        else if (xferGo)
          state_next = S_XFER;
        else if (crEmit)
          state_next = S_EMIT;
      S_XFER:
        if (xferDone)
          state_next = xferIsRead_reg ? S_EMIT : S_IDLE;
      S_EMIT:
        if (txAccept && lastOut)
          state_next = S_IDLE;
      S_PAUSE:
        if (pauseCnt_reg == '0)
          state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state_reg <= S_IDLE;
    else
      state_reg <= state_next;
  end

  // persistent settings
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      hexMode_reg <= RST_HEX_MODE;
      verbose_reg <= RST_VERBOSE;
      selN_reg <= RST_SEL_N;
      delim_reg <= RST_DELIM;
      len_reg <= RST_LEN;
      dollarPend_reg <= 1'b0;
    end
    else if (take)
    begin
      dollarPend_reg <= (rxChar == CH_SEL) && !dollarPend_reg;
      if (dollarPend_reg && (rxChar == CH_ZERO))
        selN_reg <= 1'b0;
      else if (dollarPend_reg && (rxChar == CH_ONE))
        selN_reg <= 1'b1;
      else if (lenIn)
        len_reg <= chLen;
      else if ((rxChar == CH_HEX_U) || (rxChar == CH_HEX_L))
        hexMode_reg <= (rxChar == CH_HEX_U);
      else if ((rxChar == CH_TERM_U) || (rxChar == CH_TERM_L))
        verbose_reg <= (rxChar == CH_TERM_U);
      else if (isDelimChar)
        delim_reg <= rxChar; // cr never replaces the separator
    end
  end

  // command mode and number accumulation
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mode_reg <= M_NONE;
      accum_reg <= '0;
      haveNum_reg <= 1'b0;
    end
    else if (launchWrite)
    begin
      accum_reg <= '0;
      haveNum_reg <= 1'b0;
    end
    else if (take)
    begin
      if ((rxChar == CH_WR_U) || (rxChar == CH_WR_L))
        mode_reg <= M_WRITE;
      else if ((rxChar == CH_RD_U) || (rxChar == CH_RD_L))
        mode_reg <= M_READ;
      else if (rxChar == CH_CR)
        mode_reg <= M_NONE;
      // decimal overflow keeps the low bits, as the word length truncates anyway
      haveNum_reg <= numIn && (mode_reg != M_NONE);
      if (numIn && (mode_reg != M_NONE))
        accum_reg <= hexMode_reg ? {accum_reg[WORD_W-NIB_W-1:0], nibVal}
                                 : WORD_W'(accum_reg * DEC_RADIX + nibVal);
      else
        accum_reg <= '0;
    end
  end

  // transfer launch and acknowledge crossing
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      reqToggle_reg <= 1'b0;
      txWord_reg <= '0;
      nBits_reg <= '0;
      xferIsRead_reg <= 1'b0;
      ackMeta_reg <= 1'b0;
      ackSync_reg <= 1'b0;
    end
    else
    begin
      ackMeta_reg <= xfer.ackToggle;
      ackSync_reg <= ackMeta_reg;
      if (xferGo)
      begin
        reqToggle_reg <= !reqToggle_reg;
        txWord_reg <= xferData << shAmt; // left aligned
        nBits_reg <= xferBits;
        xferIsRead_reg <= launchRead;
      end
    end
  end

  // read result formatting
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      shift_reg <= '0;
      nibLeft_reg <= '0;
      pendDelim_reg <= 1'b0;
      pendCr_reg <= 1'b0;
      outAny_reg <= 1'b0;
    end
    else if (xferDone && xferIsRead_reg)
    begin
      shift_reg <= xfer.rxWord << rxShAmt;
      nibLeft_reg <= nBits_reg >> NIB_LOG2;
      pendDelim_reg <= outAny_reg;
      pendCr_reg <= 1'b0;
      outAny_reg <= 1'b1;
    end
    else if (crEmit)
    begin
      nibLeft_reg <= '0;
      pendDelim_reg <= 1'b0;
      pendCr_reg <= 1'b1;
      outAny_reg <= 1'b0;
    end
    else if (txAccept)
    begin
      if (pendDelim_reg)
        pendDelim_reg <= 1'b0;
      else if (nibLeft_reg != '0)
      begin
        shift_reg <= shift_reg << NIB_W;
        nibLeft_reg <= BITS_W'(nibLeft_reg - 1'b1);
      end
      else
        pendCr_reg <= 1'b0;
    end
    else if (take && ((rxChar == CH_RD_U) || (rxChar == CH_RD_L)))
      outAny_reg <= 1'b0;
  end

  // tx char lags the queue one cycle, so hold valid off meanwhile
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      txChar_reg <= '0;
      stale_reg <= 1'b1;
    end
    else
    begin
      txChar_reg <= outChar;
      stale_reg <= (state_reg != S_EMIT) || txAccept;
    end
  end

  // pause counter; successive pauses run back to back
  always_ff @(posedge clk)
  begin
    if (srst)
      pauseCnt_reg <= '0;
    else if (pauseGo)
      pauseCnt_reg <= WORD_W'(PauseCycles - 1);
    else if ((state_reg == S_PAUSE) && (pauseCnt_reg != '0))
      pauseCnt_reg <= WORD_W'(pauseCnt_reg - 1'b1);
  end

  //////////////////////////////////////////////////////////////////////
  // link-side shifter on its own clock
  spi_shift_engine engine (
    .linkClk(linkClk),
    .srst(srst),
    .xfer(xfer.engine),
    .sclk(sclk),
    .mosi(mosi),
    .miso(miso)
  );
endmodule // uart_to_spi_command_bridge

// *** verification/bridge_monitor.sv ***
`timescale 1ns/1ps
module bridge_monitor #(
  parameter int PauseCycles = 20
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic linkClk,
  input wire logic [cmd_bridge_pkg::CHAR_W-1:0] rxChar,
  input wire logic rxValid,
  input wire logic rxReady,
  input wire logic [cmd_bridge_pkg::CHAR_W-1:0] txChar,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic selectLineN,
  input wire logic hexMode,
  input wire logic verboseMode,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso
);
  import cmd_bridge_pkg::*;
  // characters taken from the host, by kind
  wire take = rxValid && rxReady;
  wire takeZero = take && rxChar == CH_ZERO;
  wire takeOne = take && rxChar == CH_ONE;
  wire takeHex = take && (rxChar == CH_HEX_U || rxChar == CH_HEX_L);
  wire takeTerm = take && (rxChar == CH_TERM_U || rxChar == CH_TERM_L);
  wire hexDigit = (txChar >= CH_ZERO && txChar <= CH_NINE) || (txChar >= CH_A_LO && txChar <= CH_F_LO);
  int pauseCnt;
  // pause countdown, reloaded by each taken pause so stalls add up
  always_ff @(posedge clk)
  begin
    if (srst) pauseCnt <= 0;
    else if (take && rxChar == CH_PAUSE) pauseCnt <= PauseCycles;
    else if (pauseCnt > 0) pauseCnt <= pauseCnt - 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one sclk pulse: four link cycles high, then at least four low
  sequence sclkHigh;
    sclk [*4] ##1 !sclk;
  endsequence
  sequence sclkLow;
    !sclk [*4];
  endsequence
  a_reset_values: assert property (@(posedge clk)
    srst |=> hexMode && !verboseMode && selectLineN) else $error("reset values wrong");
  a_hex_change: assert property (@(posedge clk) disable iff (srst)
    !$stable(hexMode) |-> $past(takeHex) || $past(takeHex, 2)) else $error("hex mode moved");
  a_verbose_change: assert property (@(posedge clk) disable iff (srst)
    !$stable(verboseMode) |-> $past(takeTerm) || $past(takeTerm, 2)) else $error("verbose moved");
  a_select_low: assert property (@(posedge clk) disable iff (srst)
    $fell(selectLineN) |-> $past(takeZero) || $past(takeZero, 2)) else $error("select fell");
  a_select_high: assert property (@(posedge clk) disable iff (srst)
    $rose(selectLineN) |-> $past(takeOne) || $past(takeOne, 2)) else $error("select rose");
  a_sclk_high_span: assert property (@(posedge linkClk) disable iff (srst)
    $rose(sclk) |-> sclkHigh) else $error("sclk high span wrong");
  a_sclk_low_span: assert property (@(posedge linkClk) disable iff (srst)
    $fell(sclk) |-> sclkLow) else $error("sclk low span short");
  a_mosi_steady: assert property (@(posedge linkClk) disable iff (srst)
    sclk |-> $stable(mosi)) else $error("mosi moved while sclk high");
  a_busy_no_take: assert property (@(posedge clk) disable iff (srst)
    sclk |-> !rxReady) else $error("char taken during transfer");
  a_tx_hold: assert property (@(posedge clk) disable iff (srst)
    txValid && !txReady |=> txValid && $stable(txChar)) else $error("text dropped");
  a_tx_charset: assert property (@(posedge clk) disable iff (srst)
    txValid |-> hexDigit || txChar == CH_SPACE || txChar == CH_CR) else $error("bad text char");
  a_pause_stall: assert property (@(posedge clk) disable iff (srst)
    pauseCnt > 1 |-> !rxReady) else $error("pause cut short");
endmodule // bridge_monitor

bind uart_to_spi_command_bridge bridge_monitor #(.PauseCycles(PauseCycles)) monitor (
  .clk(clk), .srst(srst), .linkClk(linkClk), .rxChar(rxChar), .rxValid(rxValid),
  .rxReady(rxReady), .txChar(txChar), .txValid(txValid), .txReady(txReady),
  .selectLineN(selectLineN), .hexMode(hexMode), .verboseMode(verboseMode),
  .sclk(sclk), .mosi(mosi), .miso(miso));

// *** verification/spi_sensor_model.sv ***
`timescale 1ns/1ps
module spi_sensor_model (
  input wire logic sclk,
  input wire logic mosi,
  input wire logic selectLineN,
  input wire logic load,
  input wire logic [63:0] streamIn,
  output logic miso,
  output logic [63:0] seenBits,
  output int pulses
);
  logic [63:0] stream;
  logic lastBit;
  initial
  begin
    pulses = 0;
    seenBits = '0;
    lastBit = 1'b0;
  end
  // mode 0: next bit goes out on the falling edge, msb first
  always @(posedge load or negedge sclk)
  begin
    if (load) stream <= streamIn;
    else stream <= {stream[62:0], 1'b0};
  end
  // released line shows the inverse so a stale sample cannot pass
  always @(stream or selectLineN)
  begin
    if (!selectLineN) lastBit = stream[63];
  end
  assign miso = selectLineN ? ~lastBit : stream[63];
  // record every pulse and the bit it carried
  always @(posedge sclk)
  begin
    seenBits <= {seenBits[62:0], mosi};
    pulses <= pulses + 1;
  end
endmodule // spi_sensor_model

// *** verification/uart_to_spi_command_bridge_test.sv ***
`timescale 1ns/1ps
module uart_to_spi_command_bridge_test;
  import cmd_bridge_pkg::*;
  localparam int PAUSE = 20;
  localparam char_t SYNC = 8'h67; // unknown char, taken only once idle
  `define CHECK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
  logic clk = 1'b0;
  logic linkClk = 1'b0;
  logic srst = 1'b1;
  char_t rxChar = '0;
  logic rxValid = 1'b0;
  logic txReady = 1'b0;
  logic load = 1'b0;
  logic [63:0] streamIn = '0;
  logic rxReady, txValid, selectLineN, hexMode, verboseMode, sclk, mosi, miso;
  char_t txChar;
  logic [63:0] seenBits;
  int pulses;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  char_t txQ[$];
  always #2 clk = ~clk;
  always #62.5 linkClk = ~linkClk;
  uart_to_spi_command_bridge #(.PauseCycles(PAUSE)) dut (.clk(clk), .srst(srst),
    .linkClk(linkClk), .rxChar(rxChar), .rxValid(rxValid), .rxReady(rxReady),
    .txChar(txChar), .txValid(txValid), .txReady(txReady), .selectLineN(selectLineN),
    .hexMode(hexMode), .verboseMode(verboseMode), .sclk(sclk), .mosi(mosi), .miso(miso));
  spi_sensor_model sensor (.sclk(sclk), .mosi(mosi), .selectLineN(selectLineN),
    .load(load), .streamIn(streamIn), .miso(miso), .seenBits(seenBits), .pulses(pulses));
  ////////////////////////////////////////////////////////////////////////////////
  // host receiver stalls every other cycle to exercise the output hold
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    txReady <= ~txReady;
    if (txValid === 1'b1 && txReady === 1'b1) txQ.push_back(txChar);
  end
  task automatic print_verdict;
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // offer one char and hold it until the edge that takes it
  task automatic sendChar(input char_t c);
    int n;
    n = 0;
    @(posedge clk);
    rxChar <= c;
    rxValid <= 1'b1;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (rxReady !== 1'b1 && n < 20000);
    if (n >= 20000) `CHECK("rxReady", 1'b1, rxReady)
    @(posedge clk);
    rxValid <= 1'b0;
  endtask
  // sentence, then a dummy char that waits out transfers and text
  task automatic sendStr(input string s);
    foreach (s[i]) sendChar(s[i]);
    sendChar(SYNC);
  endtask
  task automatic loadStream(input logic [63:0] v);
    @(posedge clk);
    streamIn <= v;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
  endtask
  task automatic sendExpect(input string s, input int nBits, input logic [63:0] bits);
    int p0;
    p0 = pulses;
    sendStr(s);
    `CHECK("pulse count", nBits, pulses - p0)
    `CHECK("mosi bits", bits, seenBits & ((64'h1 << nBits) - 64'h1))
  endtask
  task automatic checkText(input string s);
    `CHECK("text length", s.len(), txQ.size())
    foreach (s[i]) if (i < txQ.size()) `CHECK("text char", char_t'(s[i]), txQ[i])
    txQ.delete();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    `CHECK("hexMode", 1'b1, hexMode)
    `CHECK("verboseMode", 1'b0, verboseMode)
    `CHECK("selectLineN", 1'b1, selectLineN)
    sendStr("xT");
    `CHECK("hexMode", 1'b0, hexMode)
    `CHECK("verboseMode", 1'b1, verboseMode)
    sendStr("Xt");
    `CHECK("hexMode", 1'b1, hexMode)
    `CHECK("verboseMode", 1'b0, verboseMode)
  endtask
  task automatic test_addr_read;
    loadStream(64'h0000_c800_c800_0000);
    sendStr("$0");
    `CHECK("selectLineN", 1'b0, selectLineN)
    sendExpect("r84nii\015", 40, 64'h84_0000_0000);
    checkText("00 00c8 00c8\015");
    `CHECK("selectLineN", 1'b0, selectLineN)
  endtask
  task automatic test_lengths;
    loadStream(64'h1020_3000_0000_0000);
    sendExpect("rm\015", 24, 64'h0);
    checkText("102030\015");
    sendExpect("w5\015", 24, 64'h5);
    sendExpect("wi1,n1\015", 24, 64'h101);
    sendExpect("wL7\015", 32, 64'h7);
    sendExpect("wn3,4\015", 16, 64'h304);
    checkText("");
  endtask
  task automatic test_pause;
    int t0;
    int span;
    sendChar(CH_PAUSE);
    t0 = cyc;
    sendChar(CH_PAUSE);
    sendChar(CH_SEL);
    span = cyc - t0;
    `CHECK("pause span", 1'b1, span >= 2 * PAUSE && span <= 2 * PAUSE + 8)
    sendChar(CH_ONE);
    sendChar(SYNC);
    `CHECK("selectLineN", 1'b1, selectLineN)
  endtask
  // reset spans both six clk cycles and three link edges
  initial
  begin
    repeat (6) @(posedge clk);
    repeat (3) @(posedge linkClk);
    @(posedge clk);
    srst <= 1'b0;
    test_reset();
    test_addr_read();
    test_lengths();
    test_pause();
    print_verdict();
  end
  // hang guard: about 160 link bits at 1 us each plus text, kept under 100k clk cycles
  initial
  begin
    #360_000;
    miscompares++;
    print_verdict();
  end
endmodule // uart_to_spi_command_bridge_test
